// file: rtl/fbc_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module fbc_sync (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // pins and clean levels
  input wire logic [fbc_pkg::SYNC_W-1:0] pin,
  output logic [fbc_pkg::SYNC_W-1:0] q
);
  fbc_pkg::fbc_sync_t st;
  fbc_pkg::fbc_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a bit only moves once stages two and three agree
    for (int i = 0; i < fbc_pkg::SYNC_W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;
endmodule // fbc_sync
`default_nettype wire

// file: rtl/fbc_top.sv
// feeder bay binary input, indication and switching control
// Functional notes
// - status channels one to three are open/closed pairs
// - three objects shown on user-chosen led units
// - channels four to thirteen reported on bus
// - channels four to nine each light a led
// - commands from buttons, bus or input channels
// - open/close pulse length set by user
// - pulse starts only while interlock enable is true
// - interlock from object and channel states
// - signal output follows its assigned channel
// - direct output program drives open, close, signals
// - channel seven counts external energy pulses
// - energy integrated from measured power samples
// - measured values scaled to primary quantities
// - front switch two disables both supervisions
// - front switch overrides bus supervision selection
`timescale 1ns/1ns
`default_nettype none
module fbc_top #(
  parameter int unsigned MS_CYCLES = fbc_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // status pairs: bit 2i open, bit 2i+1 closed
  input wire logic [2*fbc_pkg::N_OBJ-1:0] obj_pin,
  // single channels 4..13, bit 0 is channel 4
  input wire logic [fbc_pkg::N_CHAN-1:0] chan_pin,
  input wire logic [fbc_pkg::N_CHAN-1:0] chan_active_low,
  // front panel
  input wire logic pb_open,
  input wire logic pb_close,
  input wire logic key_remote,
  input wire logic [7:0] front_switch_group,
  // object led unit choice, four bits each
  input wire logic [4*fbc_pkg::N_OBJ-1:0] obj_led_unit,
  input wire logic [fbc_pkg::N_OBJ-1:0] obj_led_on,
  // serial bus side commands and settings
  input wire logic bus_open,
  input wire logic bus_close,
  input wire logic [1:0] trip_supervision_select,
  input wire logic [1:0] current_supervision_select,
  // command configuration
  input wire logic [3:0] open_cmd_chan,
  input wire logic [3:0] close_cmd_chan,
  input wire logic [fbc_pkg::LEN_W-1:0] pulse_len_ms,
  input wire fbc_pkg::fbc_term_t interlock_open,
  input wire fbc_pkg::fbc_term_t interlock_close,
  input wire fbc_pkg::fbc_term_t [fbc_pkg::N_DOC-1:0] doc_term,
  input wire logic [4*fbc_pkg::N_SIG-1:0] sig_chan,
  // measurement
  input wire logic counter_en,
  input wire logic power_valid,
  input wire logic signed [15:0] power_sample,
  input wire logic [15:0] meas_raw,
  input wire logic [15:0] meas_scale,
  // outputs
  output logic open_out,
  output logic close_out,
  output logic [fbc_pkg::N_SIG-1:0] signal_out,
  output logic [2*fbc_pkg::N_LED_UNIT-1:0] obj_led,
  output logic [fbc_pkg::N_CHAN_LED-1:0] chan_led,
  output logic [fbc_pkg::ST_W-1:0] bus_status,
  output logic [31:0] pulse_count,
  output logic [47:0] energy,
  output logic [31:0] scaled_value,
  output logic trip_sup_en,
  output logic cur_sup_en,
  output logic cmd_busy
);
  localparam logic [fbc_pkg::PRESC_W-1:0] PRESC_LAST = fbc_pkg::PRESC_W'(MS_CYCLES - 1);

  fbc_pkg::fbc_state_t st;
  fbc_pkg::fbc_state_t next_st;
  logic [fbc_pkg::SYNC_W-1:0] pin_q;
  logic [fbc_pkg::ST_W-1:0] stv;
  logic [fbc_pkg::N_CHAN-1:0] chan_act;
  logic [fbc_pkg::N_CHAN-1:0] chan_rise;
  logic [fbc_pkg::N_DOC-1:0] doc_hit;
  logic il_open;
  logic il_close;
  logic req_open;
  logic req_close;
  logic pb_open_rise;
  logic pb_close_rise;
  logic doc_open;
  logic doc_close;
  logic primed;

  // picks the bit of a channel numbered 4..13; other numbers mean unassigned
  function automatic logic chan_pick(input logic [fbc_pkg::N_CHAN-1:0] v,
                                     input logic [3:0] n);
    logic r;
    r = 1'b0;
    if (n >= fbc_pkg::CHAN_FIRST && n <= fbc_pkg::CHAN_LAST) begin
      r = v[4'(n - fbc_pkg::CHAN_FIRST)];
    end
    return r;
  endfunction

  // a user program term: enabled and every cared-for state bit matches
  function automatic logic term_hit(input fbc_pkg::fbc_term_t t,
                                    input logic [fbc_pkg::ST_W-1:0] s);
    return t.en && (((s ^ t.value) & t.care) == '0);
  endfunction

  fbc_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pin({1'b0, front_switch_group, key_remote, pb_close, pb_open, chan_pin, obj_pin}),
    .q(pin_q)
  );

  always_comb begin
    chan_act = pin_q[fbc_pkg::PIN_CHAN_LSB +: fbc_pkg::N_CHAN] ^ chan_active_low;
    // the pin image is stale just after reset; a level held through reset is no edge
    primed = (st.warm == fbc_pkg::WARM_DONE);
    chan_rise = primed ? (chan_act & ~st.ch_prev) : '0;
    stv = '0;
    for (int i = 0; i < fbc_pkg::N_OBJ; i++) begin
      stv[fbc_pkg::ST_OBJ_LSB + 2*i] = pin_q[fbc_pkg::PIN_OBJ_LSB + 2*i]
                                       & ~pin_q[fbc_pkg::PIN_OBJ_LSB + 2*i + 1];
      stv[fbc_pkg::ST_OBJ_LSB + 2*i + 1] = pin_q[fbc_pkg::PIN_OBJ_LSB + 2*i + 1]
                                           & ~pin_q[fbc_pkg::PIN_OBJ_LSB + 2*i];
    end
    stv[fbc_pkg::ST_CHAN_LSB +: fbc_pkg::N_CHAN] = chan_act;
    stv[fbc_pkg::ST_KEY_BIT] = pin_q[fbc_pkg::PIN_KEY];
    for (int i = 0; i < fbc_pkg::N_DOC; i++) begin
      doc_hit[i] = term_hit(doc_term[i], stv);
    end
    il_open = term_hit(interlock_open, stv);
    il_close = term_hit(interlock_close, stv);
    pb_open_rise = primed & pin_q[fbc_pkg::PIN_PB_OPEN] & ~st.pb_prev[0];
    pb_close_rise = primed & pin_q[fbc_pkg::PIN_PB_CLOSE] & ~st.pb_prev[1];
    // buttons count only in local, bus only in remote
    req_open = (pb_open_rise & ~stv[fbc_pkg::ST_KEY_BIT])
               | (bus_open & stv[fbc_pkg::ST_KEY_BIT])
               | chan_pick(chan_rise, open_cmd_chan);
    req_close = (pb_close_rise & ~stv[fbc_pkg::ST_KEY_BIT])
                | (bus_close & stv[fbc_pkg::ST_KEY_BIT])
                | chan_pick(chan_rise, close_cmd_chan);
    doc_open = doc_hit[fbc_pkg::DOC_OPEN];
    doc_close = doc_hit[fbc_pkg::DOC_CLOSE];
  end

  always_comb begin
    next_st = st;
    next_st.ch_prev = chan_act;
    next_st.pb_prev = {pin_q[fbc_pkg::PIN_PB_CLOSE], pin_q[fbc_pkg::PIN_PB_OPEN]};
    if (st.warm != fbc_pkg::WARM_DONE) begin
      next_st.warm = st.warm + 3'h1;
    end

    case (st.fsm)
      fbc_pkg::FBC_IDLE: begin
        next_st.presc = PRESC_LAST;
        next_st.remain = (pulse_len_ms == '0) ? fbc_pkg::LEN_W'(1) : pulse_len_ms;
        // a request for both at once is dropped rather than guessed
        if (req_open && !req_close && il_open) begin
          next_st.fsm = fbc_pkg::FBC_OPEN;
        end else if (req_close && !req_open && il_close) begin
          next_st.fsm = fbc_pkg::FBC_CLOSE;
        end
      end
      fbc_pkg::FBC_OPEN, fbc_pkg::FBC_CLOSE: begin
        if (st.presc == '0) begin
          next_st.presc = PRESC_LAST;
          if (st.remain == fbc_pkg::LEN_W'(1)) begin
            next_st.fsm = fbc_pkg::FBC_IDLE;
          end else begin
            next_st.remain = st.remain - fbc_pkg::LEN_W'(1);
          end
        end else begin
          next_st.presc = st.presc - fbc_pkg::PRESC_W'(1);
        end
      end
      default: begin
        next_st.fsm = fbc_pkg::FBC_IDLE;
      end
    endcase

    next_st.busy = (next_st.fsm != fbc_pkg::FBC_IDLE);
    // direct output terms may not fight a running pulse of the other kind
    next_st.open_out = (next_st.fsm == fbc_pkg::FBC_OPEN)
                       || (doc_open && !doc_close
                           && next_st.fsm != fbc_pkg::FBC_CLOSE);
    next_st.close_out = (next_st.fsm == fbc_pkg::FBC_CLOSE)
                        || (doc_close && !doc_open
                            && next_st.fsm != fbc_pkg::FBC_OPEN);

    for (int i = 0; i < fbc_pkg::N_SIG; i++) begin
      next_st.signal_out[i] = chan_pick(chan_act, sig_chan[4*i +: 4])
                              | doc_hit[fbc_pkg::DOC_SIG_LSB + i];
    end

    next_st.obj_led = '0;
    for (int i = 0; i < fbc_pkg::N_OBJ; i++) begin
      if (obj_led_on[i]) begin
        next_st.obj_led[2*obj_led_unit[4*i +: 4] +: 2] = stv[fbc_pkg::ST_OBJ_LSB + 2*i +: 2];
      end
    end
    next_st.chan_led = chan_act[fbc_pkg::N_CHAN_LED-1:0];
    next_st.bus_status = stv;

    if (counter_en && chan_rise[4'(fbc_pkg::CHAN_COUNTER - fbc_pkg::CHAN_FIRST)]) begin
      next_st.pulse_count = st.pulse_count + 32'h0000_0001;
    end
    if (power_valid) begin
      next_st.energy = st.energy + 48'(power_sample);
    end
    next_st.scaled = 32'(meas_raw) * 32'(meas_scale);

    // the local switch wins over whatever the bus selected
    next_st.trip_sup_en = !pin_q[fbc_pkg::PIN_FSW_LSB + fbc_pkg::FSW_SUP_OFF_BIT]
                          && trip_supervision_select != fbc_pkg::SUP_SEL_OFF;
    next_st.cur_sup_en = !pin_q[fbc_pkg::PIN_FSW_LSB + fbc_pkg::FSW_SUP_OFF_BIT]
                         && current_supervision_select != fbc_pkg::SUP_SEL_OFF;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign open_out = st.open_out;
  assign close_out = st.close_out;
  assign signal_out = st.signal_out;
  assign obj_led = st.obj_led;
  assign chan_led = st.chan_led;
  assign bus_status = st.bus_status;
  assign pulse_count = st.pulse_count;
  assign energy = st.energy;
  assign scaled_value = st.scaled;
  assign trip_sup_en = st.trip_sup_en;
  assign cur_sup_en = st.cur_sup_en;
  assign cmd_busy = st.busy;
endmodule // fbc_top
`default_nettype wire

// file: shared/fbc_pkg.sv
// shared constants and types for the feeder bay io control block
package fbc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned N_OBJ = 3;
  localparam int unsigned N_CHAN = 10;
  localparam int unsigned N_CHAN_LED = 6;
  localparam int unsigned N_LED_UNIT = 16;
  localparam int unsigned N_SIG = 4;
  localparam int unsigned N_DOC = 6;
  localparam int unsigned ST_W = 17;
  localparam int unsigned SYNC_W = 28;
  localparam int unsigned PRESC_W = 18;
  localparam int unsigned LEN_W = 16;
  // packed state vector layout
  localparam int unsigned ST_OBJ_LSB = 0;
  localparam int unsigned ST_CHAN_LSB = 6;
  localparam int unsigned ST_KEY_BIT = 16;
  // synchronised pin vector layout
  localparam int unsigned PIN_OBJ_LSB = 0;
  localparam int unsigned PIN_CHAN_LSB = 6;
  localparam int unsigned PIN_PB_OPEN = 16;
  localparam int unsigned PIN_PB_CLOSE = 17;
  localparam int unsigned PIN_KEY = 18;
  localparam int unsigned PIN_FSW_LSB = 19;
  localparam int unsigned FSW_SUP_OFF_BIT = 1;
  // channel numbering
  localparam logic [3:0] CHAN_FIRST = 4'h4;
  localparam logic [3:0] CHAN_LAST = 4'hD;
  localparam logic [3:0] CHAN_COUNTER = 4'h7;
  // direct output control term order
  localparam int unsigned DOC_OPEN = 0;
  localparam int unsigned DOC_CLOSE = 1;
  localparam int unsigned DOC_SIG_LSB = 2;
  localparam logic [1:0] SUP_SEL_OFF = 2'h0;
  // edges after reset before pin edges may count: synchroniser depth plus one
  localparam logic [2:0] WARM_DONE = 3'h5;
  typedef enum logic [1:0] {
    FBC_IDLE = 2'b00,
    FBC_OPEN = 2'b01,
    FBC_CLOSE = 2'b10
  } fbc_cmd_state_t;
  typedef struct packed {
    logic en;
    logic [ST_W-1:0] care;
    logic [ST_W-1:0] value;
  } fbc_term_t;
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] q;
  } fbc_sync_t;
  typedef struct packed {
    fbc_cmd_state_t fsm;
    logic [PRESC_W-1:0] presc;
    logic [LEN_W-1:0] remain;
    logic [N_CHAN-1:0] ch_prev;
    logic [1:0] pb_prev;
    logic open_out;
    logic close_out;
    logic [N_SIG-1:0] signal_out;
    logic [2*N_LED_UNIT-1:0] obj_led;
    logic [N_CHAN_LED-1:0] chan_led;
    logic [ST_W-1:0] bus_status;
    logic [31:0] pulse_count;
    logic [47:0] energy;
    logic [31:0] scaled;
    logic trip_sup_en;
    logic cur_sup_en;
    logic busy;
    logic [2:0] warm;
  } fbc_state_t;
endpackage

// file: testbench/fbc_bus_model.sv
// substation bus side: one-cycle commands and the last status report
`timescale 1ns/1ns
`default_nettype none
module fbc_bus_model (
  // clock
  input wire logic clock,
  // device side
  input wire logic [16:0] bus_status,
  output logic bus_open,
  output logic bus_close
);
  logic [16:0] report;
  initial begin
    bus_open = 1'b0;
    bus_close = 1'b0;
  end
  // status is a level, so polling each edge loses nothing
  always @(posedge clock) report <= bus_status;
  task automatic send(input logic open_cmd);
    @(posedge clock);
    bus_open <= open_cmd;
    bus_close <= !open_cmd;
    @(posedge clock);
    bus_open <= 1'b0;
    bus_close <= 1'b0;
  endtask
endmodule // fbc_bus_model
`default_nettype wire

// file: testbench/fbc_top_asserts.sv
// concurrent checks on the feeder bay io control ports
`timescale 1ns/1ns
`default_nettype none
module fbc_top_asserts #(
  parameter int unsigned MS_CYCLES = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // inputs watched
  input wire logic [15:0] pulse_len_ms,
  input wire logic counter_en,
  input wire logic power_valid,
  input wire logic signed [15:0] power_sample,
  input wire logic [7:0] front_switch_group,
  input wire logic [1:0] trip_supervision_select,
  // outputs watched
  input wire logic open_out,
  input wire logic close_out,
  input wire logic [5:0] chan_led,
  input wire logic [16:0] bus_status,
  input wire logic [31:0] pulse_count,
  input wire logic [47:0] energy,
  input wire logic trip_sup_en,
  input wire logic cur_sup_en,
  input wire logic cmd_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [31:0] busy_cnt;
  // run length of the pulse in progress, cleared whenever idle
  always_ff @(posedge clock) begin
    if (sys_rst || !cmd_busy) busy_cnt <= '0;
    else busy_cnt <= busy_cnt + 32'h1;
  end
  sequence s_start;
    $rose(cmd_busy) ##0 (open_out ^ close_out);
  endsequence
  no_overlap_a: assert property (!(open_out && close_out))
    else $error("open and close driven together");
  start_one_a: assert property ($rose(cmd_busy) |-> s_start)
    else $error("pulse start without exactly one output");
  pulse_hold_a: assert property (s_start |=> (cmd_busy && $stable({open_out, close_out})) [*2])
    else $error("pulse disturbed while busy");
  pulse_len_a: assert property ($fell(cmd_busy) |->
    busy_cnt == ((pulse_len_ms == 16'h0) ? 32'h1 : 32'(pulse_len_ms)) * MS_CYCLES)
    else $error("pulse length wrong");
  chan_led_a: assert property (chan_led == bus_status[11:6])
    else $error("channel led differs from channel state");
  obj_pair_a: assert property ((bus_status[5:0] & {1'b0, bus_status[5:1]} & 6'h15) == 6'h0)
    else $error("object open and closed together");
  sup_off_a: assert property (front_switch_group[1] [*7] |-> !trip_sup_en && !cur_sup_en)
    else $error("supervision on with switch two set");
  sup_on_a: assert property ((!front_switch_group[1] && trip_supervision_select != 2'h0) [*7]
    |-> trip_sup_en) else $error("trip supervision not enabled");
  count_step_a: assert property (!$past(sys_rst) && $changed(pulse_count) |->
    $past(counter_en) && pulse_count == $past(pulse_count) + 32'h1)
    else $error("pulse count step wrong");
  energy_sum_a: assert property (!$past(sys_rst) |-> energy == $past(energy) +
    ($past(power_valid) ? $past({{32{power_sample[15]}}, power_sample}) : 48'h0))
    else $error("energy sum wrong");
endmodule // fbc_top_asserts
`default_nettype wire

// file: testbench/fbc_top_tb.sv
// directed testbench for the feeder bay io control block
`timescale 1ns/1ns
`default_nettype none
bind fbc_top fbc_top_asserts #(.MS_CYCLES(MS_CYCLES)) chk (.*);
module fbc_top_tb;
  logic clock = 1'b0, sys_rst = 1'b1, pb_open = 1'b0, pb_close = 1'b0, key_remote = 1'b0;
  logic counter_en = 1'b0, power_valid = 1'b0, bus_open, bus_close;
  logic [5:0] obj_pin = '0;
  logic [9:0] chan_pin = '0, chan_active_low = '0;
  logic [7:0] front_switch_group = '0;
  logic [11:0] obj_led_unit = '0;
  logic [2:0] obj_led_on = '0;
  logic [1:0] trip_supervision_select = '0, current_supervision_select = '0;
  logic [3:0] open_cmd_chan = '0, close_cmd_chan = '0, signal_out;
  logic [15:0] pulse_len_ms = '0, sig_chan = '0, meas_raw = '0, meas_scale = '0;
  logic signed [15:0] power_sample = '0;
  fbc_pkg::fbc_term_t interlock_open = '0, interlock_close = '0;
  fbc_pkg::fbc_term_t [5:0] doc_term = '0;
  logic open_out, close_out, trip_sup_en, cur_sup_en, cmd_busy;
  logic [31:0] obj_led, pulse_count, scaled_value;
  logic [5:0] chan_led;
  logic [16:0] bus_status;
  logic [47:0] energy;
  logic [15:0] pw [3] = '{16'h0100, 16'hFFC0, 16'h7FFF};
  int n_fail = 0, n_compared = 0, n_open = 0, n_close = 0;
  fbc_top #(.MS_CYCLES(4)) uut (.*);
  fbc_bus_model partner (.clock(clock), .bus_status(bus_status), .bus_open(bus_open),
    .bus_close(bus_close));
  always #2 clock = ~clock;
  always @(posedge clock) begin
    if (open_out === 1'b1) n_open++;
    if (close_out === 1'b1) n_close++;
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_busy();
    for (int i = 0; i < 20; i++) begin
      if (cmd_busy === 1'b1) return;
      settle(1);
    end
    n_fail++;
    $display("CHECK FAILED at %0t: no pulse started", $time);
    stop_test();
  endtask
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    settle(1);
    check({open_out, close_out, cmd_busy, signal_out, chan_led, bus_status}, '0);
    @(posedge clock);
    // obj0 open, obj1 closed, obj2 undefined; units 3, 15 and 0
    obj_pin <= 6'h39;
    chan_pin <= 10'h0A5;
    chan_active_low <= 10'h003;
    obj_led_unit <= 12'h0F3;
    obj_led_on <= 3'h7;
    sig_chan <= 16'h06D4;
    settle(8);
    check(bus_status[5:0], 6'h09);
    check(partner.report[15:6], 10'h0A6);
    check(chan_led, 6'h26);
    check(obj_led, 32'h80000040);
    check(signal_out, 4'h4);
    obj_led_on <= 3'h5;
    chan_pin <= 10'h2A5;
    settle(6);
    check(obj_led, 32'h00000040);
    check(signal_out, 4'h6);
    doc_term[5] <= '{1'b1, 17'h10000, 17'h0};
    settle(6);
    check(signal_out, 4'hE);
    pulse_len_ms <= 16'h2;
    key_remote <= 1'b1;
    interlock_open <= '{1'b1, 17'h00040, 17'h00040};
    interlock_close <= '{1'b1, 17'h0, 17'h0};
    settle(6);
    n_open = 0;
    partner.send(1'b1);
    settle(12);
    check(n_open, 0);
    interlock_open <= '{1'b0, 17'h0, 17'h0};
    partner.send(1'b1);
    settle(12);
    check(n_open, 0);
    interlock_open <= '{1'b1, 17'h00040, 17'h0};
    partner.send(1'b1);
    wait_busy();
    // a close while the open pulse runs must be lost
    partner.send(1'b0);
    settle(12);
    check(n_open, 8);
    check(n_close, 0);
    pulse_len_ms <= 16'h0;
    close_cmd_chan <= 4'h5;
    chan_pin <= 10'h2A7;
    settle(8);
    n_close = 0;
    chan_pin <= 10'h2A5;
    settle(14);
    check(n_close, 4);
    key_remote <= 1'b0;
    pulse_len_ms <= 16'h1;
    settle(6);
    n_open = 0;
    pb_open <= 1'b1;
    settle(8);
    pb_open <= 1'b0;
    settle(8);
    check(n_open, 4);
    counter_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i == 6) counter_en <= 1'b0;
      chan_pin <= chan_pin ^ 10'h008;
      settle(6);
    end
    check(pulse_count, 32'h3);
    meas_raw <= 16'hFFFF;
    meas_scale <= 16'h0003;
    for (int i = 0; i < 3; i++) begin
      power_valid <= 1'b1;
      power_sample <= pw[i];
      @(posedge clock);
      power_valid <= 1'b0;
      @(posedge clock);
    end
    settle(2);
    check(energy, 48'h0000000080BF);
    check(scaled_value, 32'h0002FFFD);
    doc_term[0] <= '{1'b1, 17'h10000, 17'h0};
    settle(3);
    check({open_out, close_out, cmd_busy}, 3'h4);
    doc_term[1] <= '{1'b1, 17'h10000, 17'h0};
    settle(3);
    check({open_out, close_out}, 2'h0);
    doc_term[0] <= '0;
    settle(3);
    check({open_out, close_out}, 2'h1);
    doc_term[1] <= '0;
    trip_supervision_select <= 2'h1;
    current_supervision_select <= 2'h2;
    settle(7);
    check({trip_sup_en, cur_sup_en}, 2'h3);
    front_switch_group <= 8'h02;
    settle(7);
    check({trip_sup_en, cur_sup_en}, 2'h0);
    front_switch_group <= 8'h00;
    trip_supervision_select <= 2'h0;
    settle(7);
    check({trip_sup_en, cur_sup_en}, 2'h1);
    // channel five stays active through reset: that level is no new close edge
    n_close = 0;
    sys_rst <= 1'b1;
    settle(4);
    check(energy, 48'h0);
    check({open_out, close_out, cmd_busy, signal_out}, 7'h0);
    sys_rst <= 1'b0;
    settle(16);
    check(n_close, 0);
    stop_test();
  end
endmodule // fbc_top_tb
`default_nettype wire
